/* File: rtl/can_rx_consts.svh */
// Register offsets, field positions and sizes of the CAN receive buffer and filter info block
// Function
// - Count 00000 compares identifier bits only, no message data bits.
// - Buffer word 6 holds data byte 7 in bits 15-8, byte 6 in 7-0.
// - Receive buffer writes put the matched filter index into word 7 bits 12-8.
// - Filter index written by hardware only for receive buffers, never for transmit buffers.
// - Word 7 bits 15-13 and 7-0 always read as zero.
`ifndef CAN_RX_CONSTS_SVH
`define CAN_RX_CONSTS_SVH

// ==========================================================
// Register map (byte addresses)
`define OFS_CONTROL_2 8'h00
`define OFS_WORD6 8'h04
`define OFS_WORD7 8'h08
`define OFS_BUF_MODE 8'h0C
`define OFS_CMP_STATUS 8'h10

// ==========================================================
// Field positions and widths
`define COUNT_MSB 4
`define FHIT_MSB 12
`define FHIT_LSB 8
`define BYTE7_MSB 15
`define BYTE7_LSB 8
`define BYTE6_MSB 7
`define BUF_TX_BIT 0
`define STAT_MATCH_BIT 0
`define STAT_INVALID_BIT 1
`define CMP_BITS 18

// ==========================================================
// Compare count codes
`define COUNT_NONE 5'h00
`define COUNT_FIRST 5'h01
`define COUNT_MAX 5'h11
`define COUNT_LAST_SHIFT 5'h10

`endif

/* File: rtl/can_rx_pkg.sv */
// Types shared by the CAN receive buffer and filter info block
package can_rx_pkg;
   typedef logic [4:0] count_t;
   typedef logic [4:0] filter_idx_t;
   typedef logic [7:0] msg_byte_t;
   typedef logic [17:0] ident_bits_t;
   typedef logic [31:0] apb_word_t;
endpackage : can_rx_pkg

/* File: rtl/cmp_if.sv */
// Interface carrying one data-versus-identifier compare between the block and its compare unit
`timescale 1ns/1ps
interface cmp_if;
   can_rx_pkg::count_t count;
   can_rx_pkg::msg_byte_t data1;
   can_rx_pkg::msg_byte_t data2;
   can_rx_pkg::msg_byte_t data3;
   can_rx_pkg::ident_bits_t extended_identifier;
   logic match;
   logic invalid;
   modport ctl (output count, output data1, output data2, output data3, output extended_identifier,
                input match, input invalid);
   modport cmp (input count, input data1, input data2, input data3, input extended_identifier,
                output match, output invalid);
endinterface : cmp_if

/* File: rtl/data_compare_unit.sv */
// Compares leading message data bits against extended identifier bits
`timescale 1ns/1ps
`include "can_rx_consts.svh"
module data_compare_unit (
   // Compare request and result
   cmp_if.cmp cmpBus
);
   // ==========================================================
   // Mask of compared bit positions for a count code
   function automatic can_rx_pkg::ident_bits_t compMask(input can_rx_pkg::count_t c);
      can_rx_pkg::ident_bits_t m;
      m = '0;
      if (c == `COUNT_MAX) begin
         m = '1;
      end else if (c <= `COUNT_LAST_SHIFT) begin
         m = can_rx_pkg::ident_bits_t'((19'h00001 << c) - 19'h00001);
      end
      return m;
   endfunction : compMask

   // ==========================================================
   // Data stream: byte 1 bit 7 first, position k meets identifier bit k
   wire [`CMP_BITS-1:0] stream = {cmpBus.data1, cmpBus.data2, cmpBus.data3[7:6]};
   wire [`CMP_BITS-1:0] diff;
   genvar k;
   generate
      for (k = 0; k < `CMP_BITS; k = k + 1) begin : g_bit
         assign diff[k] = stream[`CMP_BITS-1-k] ^ cmpBus.extended_identifier[k];
      end
   endgenerate

   wire isNone = (cmpBus.count == `COUNT_NONE);
   wire isInvalid = (cmpBus.count > `COUNT_MAX);
   assign cmpBus.invalid = isInvalid;
   // Zero count passes on identifier alone; invalid codes never pass
   assign cmpBus.match = isNone ? 1'b1 :
                         (!isInvalid && ((diff & compMask(cmpBus.count)) == '0));
endmodule : data_compare_unit

/* File: rtl/can_rx_buffer_filter_info.sv */
// CAN receive buffer upper words, filter hit code and data compare count, APB register slave
`timescale 1ns/1ps
`include "can_rx_consts.svh"
module can_rx_buffer_filter_info (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Filter configuration and candidate message
   input wire logic [4:0] filterCompareCount,
   input wire logic candValid,
   input wire logic [17:0] candEid,
   input wire logic [7:0] candData1,
   input wire logic [7:0] candData2,
   input wire logic [7:0] candData3,
   output logic dataMatch,
   output logic compareInvalid,
   // Receive buffer store
   input wire logic rxStore,
   input wire logic [4:0] rxFilterIndex,
   input wire logic [7:0] rxByte6,
   input wire logic [7:0] rxByte7
);
   // ==========================================================
   // State
   can_rx_pkg::count_t dataCompareBitCount;
   logic [15:0] word6;
   can_rx_pkg::filter_idx_t matchedFilterIndex;
   logic bufIsTx;

   // ==========================================================
   // Compare unit
   cmp_if cmpBus ();
   assign cmpBus.count = dataCompareBitCount;
   assign cmpBus.data1 = candData1;
   assign cmpBus.data2 = candData2;
   assign cmpBus.data3 = candData3;
   assign cmpBus.extended_identifier = candEid;
   data_compare_unit u_cmp (
      .cmpBus(cmpBus)
   );

   // ==========================================================
   // APB decode
   wire access = psel && penable && !pready;
   wire done = psel && penable && pready;
   wire selCtrl = (paddr == `OFS_CONTROL_2);
   wire selW6 = (paddr == `OFS_WORD6);
   wire selW7 = (paddr == `OFS_WORD7);
   wire selMode = (paddr == `OFS_BUF_MODE);
   wire selStat = (paddr == `OFS_CMP_STATUS);
   wire mapped = selCtrl || selW6 || selW7 || selMode || selStat;
   wire wrW6 = done && pwrite && selW6;
   wire wrW7 = done && pwrite && selW7;
   wire wrMode = done && pwrite && selMode;
   wire hwStore = rxStore && !bufIsTx;

   wire [15:0] word7 = {3'h0, matchedFilterIndex, 8'h00};
   wire [31:0] readMux =
      selCtrl ? {27'h0000000, dataCompareBitCount} :
      selW6 ? {16'h0000, word6} :
      selW7 ? {16'h0000, word7} :
      selMode ? {31'h00000000, bufIsTx} :
      selStat ? {30'h00000000, compareInvalid, dataMatch} : 32'h00000000;

   // ==========================================================
   // Bus answer: one wait state, then pready for one cycle
   always_ff @(posedge clock) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= access;
         pslverr <= access && !mapped;
         if (access && !pwrite) begin
            prdata <= readMux;
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clock) begin
      if (srst) begin
         dataCompareBitCount <= `COUNT_NONE;
         bufIsTx <= 1'b0;
      end else begin
         dataCompareBitCount <= filterCompareCount;
         if (wrMode) begin
            bufIsTx <= pwdata[`BUF_TX_BIT];
         end
      end
   end

   // Hardware store wins over a software write in the same cycle
   always_ff @(posedge clock) begin
      if (srst) begin
         word6 <= 16'h0000;
         matchedFilterIndex <= 5'h00;
      end else begin
         if (hwStore) begin
            word6 <= {rxByte7, rxByte6};
            matchedFilterIndex <= rxFilterIndex;
         end else begin
            if (wrW6) begin
               word6 <= pwdata[15:0];
            end
            if (wrW7) begin
               matchedFilterIndex <= pwdata[`FHIT_MSB:`FHIT_LSB];
            end
         end
      end
   end

   // Compare result captured per candidate
   always_ff @(posedge clock) begin
      if (srst) begin
         dataMatch <= 1'b0;
         compareInvalid <= 1'b0;
      end else if (candValid) begin
         dataMatch <= cmpBus.match;
         compareInvalid <= cmpBus.invalid;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_zero_count_pass: assert property (
      (candValid && dataCompareBitCount == `COUNT_NONE) |=> dataMatch)
      else $error("zero count did not pass on identifier alone");
   a_first_bit_cmp: assert property (
      (candValid && dataCompareBitCount == `COUNT_FIRST)
      |=> dataMatch == ($past(candData1[7]) == $past(candEid[0])))
      else $error("count one compare wrong");
   a_full_cmp_last: assert property (
      (candValid && dataCompareBitCount == `COUNT_MAX
       && (candData3[6] != candEid[17])) |=> !dataMatch)
      else $error("count 17 ignored byte 3 bit 6");
   a_word6_layout: assert property (
      hwStore |=> word6 == {$past(rxByte7), $past(rxByte6)})
      else $error("word 6 byte layout wrong");
   a_filter_hit_load: assert property (
      hwStore |=> matchedFilterIndex == $past(rxFilterIndex))
      else $error("filter index not stored");
   a_tx_hold: assert property (
      (rxStore && bufIsTx && !wrW7) |=> $stable(matchedFilterIndex))
      else $error("transmit buffer filter field changed by hardware");
   a_word7_zeros: assert property (
      (done && !pwrite && selW7) |-> (prdata[15:13] == 3'h0 && prdata[7:0] == 8'h00))
      else $error("word 7 unimplemented bits not zero");
   a_invalid_code: assert property (
      (candValid && dataCompareBitCount > `COUNT_MAX) |=> (compareInvalid && !dataMatch))
      else $error("invalid count not flagged");
   a_apb_wait: assert property (
      access |=> pready ##1 !pready)
      else $error("apb answer not one wait state");

   // ==========================================================
   // Assertions: count and compare results
   a_count_copy: assert property (
      1'b1 |=> dataCompareBitCount == $past(filterCompareCount))
      else $error("compare count not copied from configuration");
   a_ctrl_upper_zero: assert property (
      (done && !pwrite && selCtrl) |-> prdata[31:5] == 27'h0000000)
      else $error("control 2 unused bits not zero");
   a_valid_code: assert property (
      (candValid && dataCompareBitCount <= `COUNT_MAX) |=> !compareInvalid)
      else $error("valid count flagged invalid");
   a_result_hold: assert property (
      !candValid |=> ($stable(dataMatch) && $stable(compareInvalid)))
      else $error("compare result changed without candidate");

   // ==========================================================
   // Assertions: buffer words and buffer mode
   a_word6_sw_write: assert property (
      (wrW6 && !hwStore) |=> word6 == $past(pwdata[15:0]))
      else $error("word 6 software write lost");
   a_word6_hold: assert property (
      (!hwStore && !wrW6) |=> $stable(word6))
      else $error("word 6 changed without store or write");
   a_tx_word6_hold: assert property (
      (rxStore && bufIsTx && !wrW6) |=> $stable(word6))
      else $error("transmit buffer data changed by hardware");
   a_index_sw_write: assert property (
      (wrW7 && !hwStore) |=> matchedFilterIndex == $past(pwdata[`FHIT_MSB:`FHIT_LSB]))
      else $error("filter index software write lost");
   a_index_hold: assert property (
      (!hwStore && !wrW7) |=> $stable(matchedFilterIndex))
      else $error("filter index changed without store or write");
   a_mode_write: assert property (
      wrMode |=> bufIsTx == $past(pwdata[`BUF_TX_BIT]))
      else $error("buffer mode write lost");
   a_mode_hold: assert property (
      !wrMode |=> $stable(bufIsTx))
      else $error("buffer mode changed without write");

   // ==========================================================
   // Assertions: register bus answers
   a_unmapped_err: assert property (
      (done && !mapped) |-> pslverr)
      else $error("unmapped access without error");
   a_unmapped_read: assert property (
      (done && !pwrite && !mapped) |-> prdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_mapped_no_err: assert property (
      (done && mapped) |-> !pslverr)
      else $error("mapped access flagged as error");
   a_pready_needs_sel: assert property (
      !psel |=> !pready)
      else $error("answer without select");
   a_read_hold: assert property (
      !(access && !pwrite) |=> $stable(prdata))
      else $error("read data changed outside a read");
   a_word6_upper_zero: assert property (
      (done && !pwrite && selW6) |-> prdata[31:16] == 16'h0000)
      else $error("word 6 upper half not zero");
   a_mode_upper_zero: assert property (
      (done && !pwrite && selMode) |-> prdata[31:1] == 31'h00000000)
      else $error("buffer mode unused bits not zero");
   a_stat_upper_zero: assert property (
      (done && !pwrite && selStat) |-> prdata[31:2] == 30'h00000000)
      else $error("status unused bits not zero");
endmodule : can_rx_buffer_filter_info

/* File: testbench/can_node_model.sv */
// Far-side CAN node model handing received messages to the buffer
`timescale 1ns/1ps
module can_node_model (
   // Clock
   input wire logic clock,
   // Request from the bench
   input wire logic send,
   input wire logic [4:0] idx,
   input wire logic [15:0] msg,
   // Receive store towards the block
   output logic rxStore,
   output logic [4:0] rxFilterIndex,
   output logic [7:0] rxByte6,
   output logic [7:0] rxByte7
);
   initial begin
      rxStore = 1'b0;
      rxFilterIndex = 5'h00;
      {rxByte7, rxByte6} = 16'h0000;
   end
   // Data is valid only with the store pulse, inverted otherwise
   always @(posedge clock) begin
      rxStore <= send;
      rxFilterIndex <= send ? idx : ~rxFilterIndex;
      {rxByte7, rxByte6} <= send ? msg : ~{rxByte7, rxByte6};
   end
endmodule : can_node_model

/* File: testbench/test_can_rx_buffer_filter_info.sv */
// Self-checking bench of the CAN receive buffer and filter info block
`timescale 1ns/1ps
`include "can_rx_consts.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module test_can_rx_buffer_filter_info;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [7:0] paddr = 8'h00, candData1 = 8'h00, candData2 = 8'h00, candData3 = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, rd, v, w;
   logic [31:0] lfsr = 32'h000002A6;
   logic [4:0] filterCompareCount = 5'h00, rxFilterIndex, idx = 5'h00;
   logic candValid = 1'b0, dataMatch, compareInvalid, rxStore, send = 1'b0;
   logic [17:0] candEid = 18'h00000, s;
   logic [7:0] rxByte6, rxByte7;
   logic [15:0] msg = 16'h0000;
   int fails = 0, n_compared = 0, cyc = 0;

   always #2 clock = ~clock;

   can_rx_buffer_filter_info uut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .filterCompareCount(filterCompareCount), .candValid(candValid),
      .candEid(candEid), .candData1(candData1), .candData2(candData2), .candData3(candData3),
      .dataMatch(dataMatch), .compareInvalid(compareInvalid), .rxStore(rxStore),
      .rxFilterIndex(rxFilterIndex), .rxByte6(rxByte6), .rxByte7(rxByte7));
   can_node_model model (.clock(clock), .send(send), .idx(idx), .msg(msg), .rxStore(rxStore),
      .rxFilterIndex(rxFilterIndex), .rxByte6(rxByte6), .rxByte7(rxByte7));

   // ==========================================================
   // Helpers
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd

   // Bit k of the result is message data stream position k
   function automatic logic [17:0] stream(logic [7:0] a, logic [7:0] b, logic [7:0] c);
      logic [17:0] r;
      for (int k = 0; k < 8; k++) begin
         r[k] = a[7-k];
         r[k+8] = b[7-k];
      end
      r[16] = c[7];
      r[17] = c[6];
      return r;
   endfunction : stream

   function automatic logic exp_match(int c, logic [17:0] e, logic [17:0] st);
      int n;
      n = (c == 17) ? 18 : c;
      if (c > 17) return 1'b0;
      return ((e ^ st) & ((18'h00001 << n) - 18'h00001)) == 18'h00000;
   endfunction : exp_match

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task store(input logic [4:0] i, input logic [15:0] m);
      @(posedge clock);
      send <= 1'b1;
      idx <= i;
      msg <= m;
      @(posedge clock);
      send <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : store

   task cand(input int c, input logic [17:0] e);
      @(posedge clock);
      candValid <= 1'b1;
      candEid <= e;
      {candData3, candData2, candData1} <= v[23:0];
      @(posedge clock);
      candValid <= 1'b0;
      @(posedge clock);
      #1;
      `CHK(dataMatch, exp_match(c, e, s))
      `CHK(compareInvalid, c > 17)
   endtask : cand

   task results();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results

   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         results();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      apb(1'b0, `OFS_WORD7, 32'h00000000);
      `CHK(rd, 32'h00000000)
      apb(1'b0, 8'h20, 32'h00000000);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h00000000)
      $display("reset and map test done");
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 32'hFFFFFFFF : rnd();
         apb(1'b1, `OFS_WORD6, v);
         apb(1'b0, `OFS_WORD6, 32'h00000000);
         `CHK(rd, {16'h0000, v[15:0]})
         apb(1'b1, `OFS_WORD7, v);
         apb(1'b0, `OFS_WORD7, 32'h00000000);
         `CHK(rd, {19'h00000, v[12:8], 8'h00})
      end
      $display("software access test done");
      apb(1'b1, `OFS_BUF_MODE, 32'h00000000);
      v = rnd();
      for (int m = 0; m < 2; m++) begin
         store(m ? ~v[4:0] : v[4:0], m ? ~v[31:16] : v[31:16]);
         if (m == 0) apb(1'b1, `OFS_BUF_MODE, 32'h00000001);
         apb(1'b0, `OFS_WORD6, 32'h00000000);
         `CHK(rd, {16'h0000, v[31:16]})
         apb(1'b0, `OFS_WORD7, 32'h00000000);
         `CHK(rd, {19'h00000, v[4:0], 8'h00})
      end
      apb(1'b0, `OFS_BUF_MODE, 32'h00000000);
      `CHK(rd, 32'h00000001)
      $display("receive store test done");
      for (int c = 0; c < 32; c++) begin
         @(posedge clock);
         filterCompareCount <= c[4:0];
         apb(1'b1, `OFS_CONTROL_2, ~{27'h0000000, c[4:0]});
         apb(1'b0, `OFS_CONTROL_2, 32'h00000000);
         `CHK(rd, {27'h0000000, c[4:0]})
         `CHK(err, 1'b0)
         v = rnd();
         w = rnd();
         s = stream(v[7:0], v[15:8], v[23:16]);
         cand(c, s);
         cand(c, w[17:0]);
         // Flip the last compared bit, then bit c, the first bit left out for counts 0 to 16
         if (c > 0) cand(c, s ^ (18'h00001 << ((c == 17) ? 17 : c - 1)));
         cand(c, s ^ (18'h00001 << c));
         apb(1'b0, `OFS_CMP_STATUS, 32'h00000000);
         `CHK(rd, {30'h00000000, c > 17, exp_match(c, s ^ (18'h00001 << c), s)})
      end
      $display("data compare count test done");
      results();
   end
endmodule : test_can_rx_buffer_filter_info
